// File: ltc_defs.vh
// register map, field layout, reset values and timing counts of the lcd
// timing control block; assumes byte addresses on a 16-bit register bus
`ifndef LTC_DEFS_VH
`define LTC_DEFS_VH

// =====================================================
// register addresses
`define LTC_ADDR_BIAS 16'hf0f0
`define LTC_ADDR_CONTRAST 16'hf0f1
`define LTC_ADDR_MODE 16'hf0f2
`define LTC_ADDR_OUTMODE 16'hf0f4
`define LTC_ADDR_SEG_BASE 16'hf100
`define LTC_SEG_COUNT 44
`define LTC_SEG_IDX_W 6

// =====================================================
// reset values
`define LTC_RST_BIAS 8'h08
`define LTC_RST_CONTRAST 8'h00
`define LTC_RST_MODE 8'h00
`define LTC_RST_OUTMODE 8'h00
`define LTC_RST_SEG 8'h00

// =====================================================
// field positions
`define LTC_BIAS_EN_BIT 0
`define LTC_MCLK_SEL_LSB 1
`define LTC_MCLK_SEL_MSB 3
`define LTC_CONTRAST_MSB 4
`define LTC_DUTY_MSB 1
`define LTC_FRAME_LSB 5
`define LTC_FRAME_MSB 6
`define LTC_OUTMODE_MSB 1

// =====================================================
// output modes
`define LTC_OM_STOP 2'h0
`define LTC_OM_ALL_OFF 2'h1
`define LTC_OM_DISPLAY 2'h2
`define LTC_OM_ALL_ON 2'h3

// =====================================================
// frame length in low-speed clock cycles per frame field code
`define LTC_FRAME_LEN_0 10'h200
`define LTC_FRAME_LEN_1 10'h1c0
`define LTC_FRAME_LEN_2 10'h180
`define LTC_FRAME_LEN_3 10'h140

// =====================================================
// whole-cycle slot length at 1/3 duty per frame field code
`define LTC_SLOT3_LEN_0 10'h0aa
`define LTC_SLOT3_LEN_1 10'h095
`define LTC_SLOT3_LEN_2 10'h080
`define LTC_SLOT3_LEN_3 10'h06a

// =====================================================
// drive level codes, 1/3 bias: ground, vl1, vl2, vl3
`define LTC_LVL_GND 2'h0
`define LTC_LVL_1 2'h1
`define LTC_LVL_2 2'h2
`define LTC_LVL_3 2'h3

`endif

// File: ltc_lcd_timing.v
// lcd drive timing control: registers, multiplier clock divider, common
// slot sequencer and digital drive level codes for commons and segments.
// assumes the low-speed clock arrives as an asynchronous pin and the
// analog bias generator turns the level codes into voltages.
// limitation: a 36-entry part leaves the top eight bank entries unused.
//
// Contract
// R1 - bias_control bit 0 enables the bias generator and resets to 0.
// R2 - bias_control bits 3-1 divide the low-speed clock by 2 to the n for the multiplier.
// R3 - the multiplier select resets to code 100, giving bias_control a reset value of 08h.
// R4 - contrast_level bits 4-0 hold a 32-step contrast code that resets to zero.
// R5 - panel_timing_mode bits 1-0 select duty 1/1, 1/2, 1/3 or 1/4, resetting to 1/1.
// R6 - panel_timing_mode bits 6-5 pick 64, 73, 85 or 102 Hz at a 32.768 kHz clock.
// R7 - at a 31.25 kHz clock the same codes give 61, 70, 81 or 97 Hz.
// R8 - frames equal the reference rate except at 1/3 duty where whole-cycle slots shorten them.
// R9 - panel_timing_mode takes byte or word access; other registers take bytes only.
// R10 - bias resets to 08h, contrast, mode and output mode to 00h, all read/write.
// R11 - a bank of 44 byte-wide read/write segment registers sits at consecutive addresses.
// R12 - output mode 00 stops with ground everywhere, 01 all off, 10 data, 11 all on.
// R13 - segment register bits 3-0 choose on or off waveform per common line.
// R14 - reset stops bias and drivers and puts ground on every common and segment.
// R15 - common slots are counted in low-speed cycles, duty phases per frame.
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "ltc_defs.vh"

module ltc_lcd_timing (
  // clock and reset
  input wire clock,
  input wire rst_b,
  // low-speed clock pin
  input wire low_speed_clock,
  // register port
  input wire [15:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_word,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  // bias generator controls
  output reg bias_enable,
  output reg mult_clk_en,
  output reg [4:0] contrast_code,
  // panel drive level codes, two bits per line
  output reg [7:0] com_level,
  output reg [87:0] seg_level,
  output reg frame_start
);

  // =====================================================
  // low-speed clock sampling
  reg ls_s1_q;
  reg ls_s2_q;
  reg ls_s3_q;
  reg ls_lvl_q;
  wire ls_agree;
  wire ls_rise;

  // a level counts only when the second and third stage agree
  assign ls_agree = (ls_s2_q == ls_s3_q);
  assign ls_rise = ls_agree && ls_s3_q && !ls_lvl_q;

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ls_s1_q <= 1'b0;
      ls_s2_q <= 1'b0;
      ls_s3_q <= 1'b0;
      ls_lvl_q <= 1'b0;
    end else begin
      ls_s1_q <= low_speed_clock;
      ls_s2_q <= ls_s1_q;
      ls_s3_q <= ls_s2_q;
      if (ls_agree) begin
        ls_lvl_q <= ls_s3_q;
      end
    end
  end

  // =====================================================
  // registers
  reg [7:0] bias_q;
  reg [7:0] contrast_q;
  reg [7:0] mode_q;
  reg [7:0] outmode_q;
  reg [7:0] seg_mem_q [0:`LTC_SEG_COUNT-1];
  wire [15:0] seg_off;
  wire seg_hit;
  wire [`LTC_SEG_IDX_W-1:0] seg_idx;
  wire hit_bias;
  wire hit_contrast;
  wire hit_mode;
  wire hit_outmode;
  integer i;

  assign seg_off = reg_addr - `LTC_ADDR_SEG_BASE;
  assign seg_hit = (reg_addr >= `LTC_ADDR_SEG_BASE) && (seg_off < `LTC_SEG_COUNT);
  assign seg_idx = seg_off[`LTC_SEG_IDX_W-1:0];
  assign hit_bias = (reg_addr == `LTC_ADDR_BIAS);
  assign hit_contrast = (reg_addr == `LTC_ADDR_CONTRAST);
  assign hit_mode = (reg_addr == `LTC_ADDR_MODE);
  assign hit_outmode = (reg_addr == `LTC_ADDR_OUTMODE);

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bias_q <= `LTC_RST_BIAS; // [R3] [R10] [R14]
      contrast_q <= `LTC_RST_CONTRAST; // [R4] [R10]
      mode_q <= `LTC_RST_MODE; // [R10]
      outmode_q <= `LTC_RST_OUTMODE; // [R10] [R14]
      for (i = 0; i < `LTC_SEG_COUNT; i = i + 1) begin
        seg_mem_q[i] <= `LTC_RST_SEG;
      end
    end else if (reg_wr) begin
      // word writes only land on the mode register; its high byte has no storage
      if (hit_mode) begin
        mode_q <= reg_wdata[7:0]; // [R9]
      end else if (!reg_word) begin
        if (hit_bias) begin
          bias_q <= reg_wdata[7:0]; // [R1] [R2]
        end else if (hit_contrast) begin
          contrast_q <= reg_wdata[7:0]; // [R4]
        end else if (hit_outmode) begin
          outmode_q <= reg_wdata[7:0]; // [R12]
        end else if (seg_hit) begin
          seg_mem_q[seg_idx] <= reg_wdata[7:0]; // [R11]
        end
      end
    end
  end

  // =====================================================
  // read path, data one cycle after the strobe
  reg [7:0] rd_byte;

  always @* begin
    rd_byte = 8'h00;
    if (hit_bias) begin
      rd_byte = bias_q;
    end else if (hit_contrast) begin
      rd_byte = contrast_q;
    end else if (hit_mode) begin
      rd_byte = mode_q;
    end else if (hit_outmode) begin
      rd_byte = outmode_q;
    end else if (seg_hit) begin
      rd_byte = seg_mem_q[seg_idx];
    end
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      // byte-only registers answer a word read with zero
      if (reg_word && !hit_mode) begin
        reg_rdata <= 16'h0000; // [R9]
      end else begin
        reg_rdata <= {8'h00, rd_byte};
      end
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // =====================================================
  // field decode
  wire bias_on;
  wire [2:0] mclk_sel;
  wire [1:0] duty_sel;
  wire [1:0] frame_sel;
  wire [1:0] out_mode;

  assign bias_on = bias_q[`LTC_BIAS_EN_BIT]; // [R1]
  assign mclk_sel = bias_q[`LTC_MCLK_SEL_MSB:`LTC_MCLK_SEL_LSB]; // [R2]
  assign duty_sel = mode_q[`LTC_DUTY_MSB:0]; // [R5]
  assign frame_sel = mode_q[`LTC_FRAME_MSB:`LTC_FRAME_LSB]; // [R6]
  assign out_mode = outmode_q[`LTC_OUTMODE_MSB:0]; // [R12]

  // =====================================================
  // multiplier clock divider
  reg [6:0] mdiv_q;
  reg [6:0] mdiv_mask;

  always @* begin
    mdiv_mask = 7'h00;
    case (mclk_sel)
      3'h0: mdiv_mask = 7'h00;
      3'h1: mdiv_mask = 7'h01;
      3'h2: mdiv_mask = 7'h03;
      3'h3: mdiv_mask = 7'h07;
      3'h4: mdiv_mask = 7'h0f;
      3'h5: mdiv_mask = 7'h1f;
      3'h6: mdiv_mask = 7'h3f;
      default: mdiv_mask = 7'h7f;
    endcase
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      mdiv_q <= 7'h00;
      mult_clk_en <= 1'b0;
      bias_enable <= 1'b0;
      contrast_code <= 5'h00;
    end else begin
      bias_enable <= bias_on; // [R1]
      contrast_code <= contrast_q[`LTC_CONTRAST_MSB:0]; // [R4]
      mult_clk_en <= 1'b0;
      if (!bias_on) begin
        mdiv_q <= 7'h00;
      end else if (ls_rise) begin
        mdiv_q <= mdiv_q + 7'h01;
        // one pulse every 2 to the n low-speed edges
        mult_clk_en <= ((mdiv_q & mdiv_mask) == mdiv_mask); // [R2]
      end
    end
  end

  // =====================================================
  // common slot sequencer
  reg [9:0] frame_len;
  reg [9:0] slot_len;
  reg [9:0] third_len;
  reg [1:0] last_phase;
  reg [9:0] slot_cnt_q;
  reg [1:0] phase_q;
  reg polarity_q;
  wire run;
  wire slot_end;

  // frame lengths give 64/73/85/102 Hz at 32.768 kHz and 61/70/81/97 Hz at 31.25 kHz
  always @* begin
    frame_len = `LTC_FRAME_LEN_0;
    case (frame_sel)
      2'h0: frame_len = `LTC_FRAME_LEN_0; // [R6] [R7]
      2'h1: frame_len = `LTC_FRAME_LEN_1;
      2'h2: frame_len = `LTC_FRAME_LEN_2;
      default: frame_len = `LTC_FRAME_LEN_3;
    endcase
  end

  // whole slots at 1/3 duty come from a table, keeping a divider off the slot path
  always @* begin
    third_len = `LTC_SLOT3_LEN_0;
    case (frame_sel)
      2'h0: third_len = `LTC_SLOT3_LEN_0; // [R8]
      2'h1: third_len = `LTC_SLOT3_LEN_1;
      2'h2: third_len = `LTC_SLOT3_LEN_2;
      default: third_len = `LTC_SLOT3_LEN_3;
    endcase
  end

  // 1/3 duty truncates the slot, so the frame runs slightly fast except at frame code 2, where 384 divides by 3
  always @* begin
    slot_len = frame_len;
    last_phase = duty_sel; // [R5]
    case (duty_sel)
      2'h0: slot_len = frame_len;
      2'h1: slot_len = {1'b0, frame_len[9:1]};
      2'h2: slot_len = third_len; // [R8]
      default: slot_len = {2'b00, frame_len[9:2]};
    endcase
  end

  assign run = (out_mode != `LTC_OM_STOP);
  assign slot_end = ls_rise && (slot_cnt_q >= slot_len - 10'h001);

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      slot_cnt_q <= 10'h000;
      phase_q <= 2'h0;
      polarity_q <= 1'b0;
      frame_start <= 1'b0;
    end else begin
      frame_start <= 1'b0;
      if (!run) begin
        slot_cnt_q <= 10'h000;
        phase_q <= 2'h0;
        polarity_q <= 1'b0;
      end else if (slot_end) begin
        slot_cnt_q <= 10'h000; // [R15]
        if (phase_q >= last_phase) begin
          phase_q <= 2'h0;
          // alternate polarity each frame to keep the glass free of dc
          polarity_q <= !polarity_q;
          frame_start <= 1'b1;
        end else begin
          phase_q <= phase_q + 2'h1; // [R15]
        end
      end else if (ls_rise) begin
        slot_cnt_q <= slot_cnt_q + 10'h001; // [R15]
      end
    end
  end

  // =====================================================
  // drive level codes
  reg [7:0] com_d;
  reg [87:0] seg_d;
  reg seg_on;
  integer c;
  integer s;

  always @* begin
    com_d = 8'h00;
    seg_d = 88'h0;
    seg_on = 1'b0;
    for (c = 0; c < 4; c = c + 1) begin
      if (!run) begin
        com_d[c*2 +: 2] = `LTC_LVL_GND; // [R12] [R14]
      end else if ((c <= last_phase) && (c == phase_q)) begin
        com_d[c*2 +: 2] = polarity_q ? `LTC_LVL_GND : `LTC_LVL_3;
      end else begin
        com_d[c*2 +: 2] = polarity_q ? `LTC_LVL_2 : `LTC_LVL_1;
      end
    end
    for (s = 0; s < `LTC_SEG_COUNT; s = s + 1) begin
      case (out_mode)
        `LTC_OM_ALL_OFF: seg_on = 1'b0; // [R12]
        `LTC_OM_ALL_ON: seg_on = 1'b1; // [R12]
        `LTC_OM_DISPLAY: seg_on = seg_mem_q[s][phase_q]; // [R13]
        default: seg_on = 1'b0;
      endcase
      if (!run) begin
        seg_d[s*2 +: 2] = `LTC_LVL_GND; // [R12] [R14]
      end else if (seg_on) begin
        seg_d[s*2 +: 2] = polarity_q ? `LTC_LVL_3 : `LTC_LVL_GND;
      end else begin
        seg_d[s*2 +: 2] = polarity_q ? `LTC_LVL_1 : `LTC_LVL_2;
      end
    end
  end

  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      com_level <= 8'h00; // [R14]
      seg_level <= 88'h0; // [R14]
    end else begin
      com_level <= com_d;
      seg_level <= seg_d;
    end
  end

endmodule // ltc_lcd_timing

`default_nettype wire

// File: ltc_lcd_timing_chk.sv
// port checker for the lcd timing control block
// assumes bind onto ltc_lcd_timing, one clock domain
`timescale 1ns/10ps
`default_nettype none
`include "ltc_defs.vh"
module ltc_lcd_timing_chk (
  // clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // register port
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_word,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // drive side
  input wire logic bias_enable,
  input wire logic mult_clk_en,
  input wire logic [4:0] contrast_code,
  input wire logic [7:0] com_level,
  input wire logic [87:0] seg_level,
  input wire logic frame_start
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // ==========
  // output mode mirror; word writes are refused there
  logic [1:0] om_q;
  wire wr_byte = reg_wr && !reg_word;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) om_q <= 2'h0;
    else if (wr_byte && reg_addr == `LTC_ADDR_OUTMODE) om_q <= reg_wdata[1:0];
  end
  // ==========
  // register copies, seen two edges after a byte write
  bias_follow_a: assert property (wr_byte && reg_addr == `LTC_ADDR_BIAS
    |-> ##2 bias_enable == $past(reg_wdata[0], 2))
    else $error("bias enable off its register");
  contrast_follow_a: assert property (wr_byte && reg_addr == `LTC_ADDR_CONTRAST
    |-> ##2 contrast_code == $past(reg_wdata[4:0], 2))
    else $error("contrast code off its register");
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside its cycle");
  refused_read_a: assert property (reg_rd && reg_word && reg_addr != `LTC_ADDR_MODE
    |=> reg_rdata == 16'h0000) else $error("word read not refused");
  frame_pulse_a: assert property (frame_start |=> !frame_start)
    else $error("frame pulse too long");
  mult_pulse_a: assert property (mult_clk_en |=> !mult_clk_en [*5])
    else $error("multiplier pulses too close");
  mult_off_a: assert property (!bias_enable [*3] |-> !mult_clk_en)
    else $error("multiplier clock while bias off");
  stop_gnd_a: assert property ((om_q == 2'h0) [*4] |-> com_level == 8'h00 && seg_level == 88'h0)
    else $error("stop mode not at ground");
  all_on_a: assert property ((om_q == 2'h3) [*4] |-> seg_level[1:0] inside {2'h0, 2'h3})
    else $error("all on mode shows off level");
  all_off_a: assert property ((om_q == 2'h1) [*4] |-> seg_level[1:0] inside {2'h1, 2'h2})
    else $error("all off mode shows on level");
  // ==========
  frame_c: cover property (frame_start);
  mult_c: cover property (mult_clk_en);
  word_c: cover property (reg_rd && reg_word);
endmodule // ltc_lcd_timing_chk
bind ltc_lcd_timing ltc_lcd_timing_chk ltc_lcd_timing_chk_i (.clock(clock), .rst_b(rst_b),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_word(reg_word), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bias_enable(bias_enable),
  .mult_clk_en(mult_clk_en), .contrast_code(contrast_code), .com_level(com_level),
  .seg_level(seg_level), .frame_start(frame_start));
`default_nettype wire

// File: ltc_panel.sv
// panel model: lit state of segments 0 and 1 on common 0
// assumes level codes 0 gnd to 3 vl3
`timescale 1ns/10ps
`default_nettype none
module ltc_panel (
  // drive levels
  input wire logic [7:0] com_level,
  input wire logic [87:0] seg_level,
  // lit dots
  output logic [1:0] lit
);
  // a dot lights only across the full swing, not the bias steps
  assign lit[0] = {com_level[1:0], seg_level[1:0]} inside {4'h3, 4'hc};
  assign lit[1] = {com_level[1:0], seg_level[3:2]} inside {4'h3, 4'hc};
endmodule // ltc_panel
`default_nettype wire

// File: tb_top.sv
// testbench for the lcd timing control block
// assumes a low-speed clock of ten system clocks
`timescale 1ns/10ps
`default_nettype none
`include "ltc_defs.vh"
module tb_top;
  logic clock, rst_b, low_speed_clock, reg_word, reg_wr, reg_rd;
  logic [15:0] reg_addr, reg_wdata;
  wire [15:0] reg_rdata;
  wire bias_enable, mult_clk_en, frame_start;
  wire [4:0] contrast_code;
  wire [7:0] com_level;
  wire [87:0] seg_level;
  wire [1:0] lit;
  int err_total = 0, samples_checked = 0, cyc = 0, n, k;
  logic [31:0] v;
  ltc_lcd_timing ltc_lcd_timing_i (.clock(clock), .rst_b(rst_b),
    .low_speed_clock(low_speed_clock), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_word(reg_word), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .bias_enable(bias_enable), .mult_clk_en(mult_clk_en), .contrast_code(contrast_code),
    .com_level(com_level), .seg_level(seg_level), .frame_start(frame_start));
  ltc_panel ltc_panel_i (.com_level(com_level), .seg_level(seg_level), .lit(lit));
  // ==========
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // offset phase, so low-speed edges never coincide with a system clock edge
  initial begin
    low_speed_clock = 1'b0;
    #3;
    forever #50 low_speed_clock = ~low_speed_clock;
  end
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_total = err_total + 1;
      end_sim();
    end
  end
  // ==========
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic w);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_word <= w;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic w, input logic [15:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_word <= w;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, e);
  endtask
  // cycles between two pulses, rounded to low-speed periods
  task automatic span(input bit f, output int p);
    for (k = 0; k < 30000 && !(f ? frame_start : mult_clk_en); k++) @(negedge clock);
    @(negedge clock);
    for (p = 1; p < 30000 && !(f ? frame_start : mult_clk_en); p++) @(negedge clock);
    p = (p + 5) / 10;
  endtask
  // 1/3 duty drops the slot remainder
  function automatic int frame_exp(input int f, input int d);
    return ((512 - 64 * f) / (d + 1)) * (d + 1);
  endfunction
  // ==========
  initial begin
    {rst_b, reg_word, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    v = $urandom(32'h959b);
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    rd(`LTC_ADDR_BIAS, 1'b0, 16'h0008);
    rd(`LTC_ADDR_CONTRAST, 1'b0, 16'h0000);
    rd(`LTC_ADDR_MODE, 1'b0, 16'h0000);
    rd(`LTC_ADDR_OUTMODE, 1'b0, 16'h0000);
    rd(16'hf12b, 1'b0, 16'h0000);
    chk({bias_enable, |com_level, |seg_level}, 0);
    $display("reset test done");
    for (int i = 0; i < 8; i++) begin
      v = $urandom;
      wr(`LTC_ADDR_CONTRAST, {8'h00, v[7:0]}, 1'b0);
      rd(`LTC_ADDR_CONTRAST, 1'b0, {8'h00, v[7:0]});
      chk(contrast_code, v[4:0]);
      n = (i == 0) ? 43 : v[15:8] % 44;
      wr(`LTC_ADDR_SEG_BASE + n[15:0], {8'h00, v[23:16]}, 1'b0);
      rd(`LTC_ADDR_SEG_BASE + n[15:0], 1'b0, {8'h00, v[23:16]});
    end
    rd(16'hf12c, 1'b0, 16'h0000);
    $display("random register test done");
    wr(`LTC_ADDR_MODE, 16'hab61, 1'b1);
    rd(`LTC_ADDR_MODE, 1'b0, 16'h0061);
    rd(`LTC_ADDR_MODE, 1'b1, 16'h0061);
    wr(`LTC_ADDR_CONTRAST, 16'h0015, 1'b1);
    rd(`LTC_ADDR_CONTRAST, 1'b0, {8'h00, v[7:0]});
    rd(`LTC_ADDR_CONTRAST, 1'b1, 16'h0000);
    $display("access size test done");
    for (int b = 0; b < 3; b++) begin
      v = (b == 2) ? $urandom % 8 : b * 4;
      wr(`LTC_ADDR_BIAS, {12'h000, v[2:0], 1'b1}, 1'b0);
      span(1'b0, n);
      chk(n, 1 << v[2:0]);
    end
    wr(`LTC_ADDR_BIAS, 16'h0008, 1'b0);
    repeat (3) @(posedge clock);
    chk(bias_enable, 0);
    $display("multiplier test done");
    wr(`LTC_ADDR_OUTMODE, 16'h0002, 1'b0);
    for (int i = 0; i < 4; i++) begin
      wr(`LTC_ADDR_MODE, 16'h0060 - 16'h0020 * i + i, 1'b0);
      span(1'b1, n);
      span(1'b1, n);
      chk(n, frame_exp(3 - i, i));
    end
    $display("frame test done");
    wr(`LTC_ADDR_MODE, 16'h0000, 1'b0);
    wr(`LTC_ADDR_SEG_BASE, 16'h0001, 1'b0);
    wr(`LTC_ADDR_SEG_BASE + 16'h0001, 16'h000e, 1'b0);
    for (int m = 0; m < 4; m++) begin
      wr(`LTC_ADDR_OUTMODE, (m + 1) % 4, 1'b0);
      repeat (10) @(negedge clock);
      chk(lit, m == 0 ? 2'h0 : m == 1 ? 2'h1 : m == 2 ? 2'h3 : 2'h0);
    end
    chk({|com_level, |seg_level}, 0);
    $display("output mode test done");
    wr(`LTC_ADDR_OUTMODE, 16'h0003, 1'b0);
    wr(`LTC_ADDR_BIAS, 16'h0005, 1'b0);
    @(posedge clock);
    rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    rd(`LTC_ADDR_BIAS, 1'b0, 16'h0008);
    rd(`LTC_ADDR_CONTRAST, 1'b0, 16'h0000);
    chk({bias_enable, |com_level, |seg_level}, 0);
    $display("second reset test done");
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
